// ==== pcp_clock_ctrl.sv ====
/*
 * clock configuration block: protected divider/multiplier settings, clock source choice,
 * lock synchroniser and lock-change interrupt, reached over apb.
 * assumes apb signals and status inputs synchronous to core_clk; pll_lock_in is asynchronous.
 */
// The APB slave port was left to the implementer.
//
// Contract
// RL1: a protection bit guards the multiplier, reference divider, clock select, pll, trim and oscillator registers.
// RL2: writing 0x26 to the protection register clears the bit and any other value sets it.
// RL3: while the protection bit is 1 the guarded registers ignore writes, while 0 they accept them.
// RL4: with the oscillator disabled the reference is the internal rc clock of 1MHz.
// RL5: with the oscillator enabled the reference is the oscillator divided by the divider field plus one.
// RL6: the vco runs at twice the reference times the multiplier field plus one.
// RL7: when locked the pll output is the vco divided by the post-divider field plus one.
// RL8: while unlocked the pll output is the vco divided by four.
// RL9: with the pll selected the bus clock is half the pll output.
// RL10: software must not program settings that push the bus clock past its limit.
// RL11: with the pll not selected and the oscillator qualified the system runs from the oscillator at half rate.
// RL12: the pll select bit clears only while the oscillator is qualified and is forced set otherwise or in full stop.
// RL13: a lock change sets a flag cleared by writing one, which requests an interrupt when enabled.
// RL14: the lock indication is synchronised to the bus clock and picks the post-divider or divide-by-four.
`timescale 1ns/100ps
`include "pcp_regs.svh"

module pcp_clock_ctrl
	import pcp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PCP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pll_lock_in,
	input wire logic osc_qualified,
	input wire logic full_stop,
	output logic irq,
	output pcp_clk_cfg_type clk_cfg
);

	pcp_state_type s_reg;
	pcp_state_type s_next;

	function automatic logic hit(input logic [`PCP_ADDR_W-1:0] a, input logic [9:0] idx);
		hit = (a[1:0] == 2'h0) && (a[`PCP_ADDR_W-1:2] == idx);
	endfunction

	logic wr_go;
	logic rd_setup;
	logic guard_ok;
	logic mapped;
	logic [31:0] rdata;

	always_comb
	begin
		s_next = s_reg;
		wr_go = psel && penable && pwrite && s_reg.pready;
		rd_setup = psel && penable && !s_reg.pready;
		guard_ok = !s_reg.protection_active_bit; // see RL3
		mapped = hit(paddr, `PCP_IDX_MULT) || hit(paddr, `PCP_IDX_REFERENCE_DIVIDER)
			|| hit(paddr, `PCP_IDX_STATUS) || hit(paddr, `PCP_IDX_MASK)
			|| hit(paddr, `PCP_IDX_CLKSEL) || hit(paddr, `PCP_IDX_PLLCFG)
			|| hit(paddr, `PCP_IDX_TRIMH) || hit(paddr, `PCP_IDX_TRIML)
			|| hit(paddr, `PCP_IDX_OSC) || hit(paddr, `PCP_IDX_PROTECTION_ACTIVE_BIT)
			|| hit(paddr, `PCP_IDX_OSC2);

		// one wait state: pready rises in the second access cycle
		s_next.pready = rd_setup;
		s_next.pslverr = rd_setup && !mapped;

		rdata = 32'h0000_0000;
		if (hit(paddr, `PCP_IDX_MULT))
			rdata[5:0] = s_reg.vco_multiplier;
		if (hit(paddr, `PCP_IDX_REFERENCE_DIVIDER))
			rdata[3:0] = s_reg.reference_divider;
		if (hit(paddr, `PCP_IDX_STATUS))
		begin
			rdata[`PCP_BIT_LOCK_FLAG] = s_reg.lock_change_flag;
			rdata[`PCP_BIT_LOCK_STAT] = s_reg.lock_sync;
		end
		if (hit(paddr, `PCP_IDX_MASK))
			rdata[`PCP_BIT_LOCK_FLAG] = s_reg.lock_change_irq_enable;
		if (hit(paddr, `PCP_IDX_CLKSEL))
			rdata[`PCP_BIT_PLL_SEL] = s_reg.pll_source_select;
		if (hit(paddr, `PCP_IDX_PLLCFG))
			rdata[4:0] = s_reg.output_post_divider;
		if (hit(paddr, `PCP_IDX_TRIMH))
			rdata[7:0] = s_reg.trim_high;
		if (hit(paddr, `PCP_IDX_TRIML))
			rdata[7:0] = s_reg.trim_low;
		if (hit(paddr, `PCP_IDX_OSC))
			rdata[`PCP_BIT_OSC_EN] = s_reg.osc_enable_bit;
		if (hit(paddr, `PCP_IDX_PROTECTION_ACTIVE_BIT))
			rdata[`PCP_BIT_PROTECTION_ACTIVE_BIT] = s_reg.protection_active_bit;
		if (hit(paddr, `PCP_IDX_OSC2))
			rdata[1:0] = s_reg.osc_mode;
		s_next.prdata = (rd_setup && !pwrite) ? rdata : 32'h0000_0000;

		// register writes
		if (wr_go && hit(paddr, `PCP_IDX_PROTECTION_ACTIVE_BIT))
			s_next.protection_active_bit = (pwdata[7:0] != `PCP_UNLOCK_KEY); // see RL2
		if (wr_go && guard_ok) // see RL1
		begin
			if (hit(paddr, `PCP_IDX_MULT))
				s_next.vco_multiplier = pwdata[5:0];
			if (hit(paddr, `PCP_IDX_REFERENCE_DIVIDER))
				s_next.reference_divider = pwdata[3:0];
			if (hit(paddr, `PCP_IDX_PLLCFG))
				s_next.output_post_divider = pwdata[4:0];
			if (hit(paddr, `PCP_IDX_TRIMH))
				s_next.trim_high = pwdata[7:0];
			if (hit(paddr, `PCP_IDX_TRIML))
				s_next.trim_low = pwdata[7:0];
			if (hit(paddr, `PCP_IDX_OSC))
				s_next.osc_enable_bit = pwdata[`PCP_BIT_OSC_EN];
			if (hit(paddr, `PCP_IDX_OSC2))
				s_next.osc_mode = pwdata[1:0];
			if (hit(paddr, `PCP_IDX_CLKSEL) && (pwdata[`PCP_BIT_PLL_SEL] || osc_qualified))
				s_next.pll_source_select = pwdata[`PCP_BIT_PLL_SEL]; // see RL12
		end
		if (!osc_qualified || full_stop)
			s_next.pll_source_select = 1'b1; // see RL12
		if (wr_go && hit(paddr, `PCP_IDX_MASK))
			s_next.lock_change_irq_enable = pwdata[`PCP_BIT_LOCK_FLAG];

		// lock synchroniser and change flag; a change wins over a clear
		s_next.lock_meta = pll_lock_in; // see RL14
		s_next.lock_sync = s_reg.lock_meta;
		s_next.lock_prev = s_reg.lock_sync;
		if (wr_go && hit(paddr, `PCP_IDX_STATUS) && pwdata[`PCP_BIT_LOCK_FLAG])
			s_next.lock_change_flag = 1'b0; // see RL13
		if (s_reg.lock_sync != s_reg.lock_prev)
			s_next.lock_change_flag = 1'b1; // see RL13
		s_next.irq = s_next.lock_change_flag && s_next.lock_change_irq_enable; // see RL13

		// clock settings presented as ratios
		s_next.cfg.ref_from_osc = s_next.osc_enable_bit; // see RL4
		s_next.cfg.ref_div = s_next.osc_enable_bit
			? {1'b0, s_next.reference_divider} + 5'h01 : 5'h01; // see RL5
		s_next.cfg.vco_mult = {1'b0, s_next.vco_multiplier, 1'b0} + 8'h02; // see RL6
		s_next.cfg.pll_div = s_next.lock_sync
			? {1'b0, s_next.output_post_divider} + 6'h01 // see RL7
			: `PCP_UNLOCKED_DIV; // see RL8
		s_next.cfg.sys_from_pll = s_next.pll_source_select;
		s_next.cfg.sys_from_osc = !s_next.pll_source_select && osc_qualified; // see RL11
		s_next.cfg.bus_div = `PCP_BUS_DIV; // see RL9
		s_next.cfg.rc_trim = {s_next.trim_high, s_next.trim_low};
		s_next.cfg.osc_mode = s_next.osc_mode;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			s_reg <= '0;
			s_reg.vco_multiplier <= `PCP_RST_MULT;
			s_reg.reference_divider <= `PCP_RST_REFERENCE_DIVIDER;
			s_reg.output_post_divider <= `PCP_RST_POST;
			s_reg.pll_source_select <= 1'b1;
			s_reg.trim_high <= `PCP_RST_TRIM;
			s_reg.trim_low <= `PCP_RST_TRIM;
			s_reg.osc_mode <= `PCP_RST_OSC2;
			s_reg.cfg.ref_div <= 5'h01;
			s_reg.cfg.vco_mult <= 8'h02;
			s_reg.cfg.pll_div <= `PCP_UNLOCKED_DIV;
			s_reg.cfg.sys_from_pll <= 1'b1;
			s_reg.cfg.bus_div <= `PCP_BUS_DIV;
		end
		else if (clk_en)
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;
	assign clk_cfg = s_reg.cfg;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn || !clk_en);

	logic protection_active_bit_wr;
	assign protection_active_bit_wr = psel && penable && pwrite && pready && hit(paddr, `PCP_IDX_PROTECTION_ACTIVE_BIT);

	key_unlock_a: assert property (protection_active_bit_wr && pwdata[7:0] == `PCP_UNLOCK_KEY // see RL2
		|=> !s_reg.protection_active_bit) else $error("key write did not unlock");
	other_lock_a: assert property (protection_active_bit_wr && pwdata[7:0] != `PCP_UNLOCK_KEY // see RL2
		|=> s_reg.protection_active_bit) else $error("non-key write did not lock");
	guard_hold_a: assert property (s_reg.protection_active_bit && !protection_active_bit_wr // see RL3
		|=> $stable(s_reg.vco_multiplier) && $stable(s_reg.reference_divider)
		&& $stable(s_reg.output_post_divider)) else $error("guarded register changed");
	ref_source_a: assert property (clk_cfg.ref_from_osc // see RL5
		|-> clk_cfg.ref_div == {1'b0, s_reg.reference_divider} + 5'h01)
		else $error("reference divider ratio wrong");
	rc_ref_a: assert property (!s_reg.osc_enable_bit |-> clk_cfg.ref_div == 5'h01 // see RL4
		&& !clk_cfg.ref_from_osc) else $error("rc reference not chosen");
	vco_ratio_a: assert property (clk_cfg.vco_mult // see RL6
		== 8'(2 * (s_reg.vco_multiplier + 1))) else $error("vco ratio wrong");
	pll_div_a: assert property (clk_cfg.pll_div == (s_reg.lock_sync // see RL7
		? {1'b0, s_reg.output_post_divider} + 6'h01 : 6'h04)) else $error("pll ratio wrong");
	sel_force_a: assert property (!osc_qualified |=> s_reg.pll_source_select) // see RL12
		else $error("pll select not forced");
	flag_set_a: assert property (s_reg.lock_sync != s_reg.lock_prev // see RL13
		|=> s_reg.lock_change_flag) else $error("lock change not flagged");
	irq_out_a: assert property (s_reg.lock_change_flag && s_reg.lock_change_irq_enable // see RL13
		|-> irq) else $error("interrupt missing");
	lock_sync_a: assert property (s_reg.lock_sync == $past(pll_lock_in, 2)) // see RL14
		else $error("lock synchroniser delay wrong");
	answer_time_a: assert property (psel && !penable ##1 psel && penable |=> pready)
		else $error("apb answer late");


	// apb answer shape
	logic data_wr;
	assign data_wr = psel && penable && pwrite && pready;

	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");

	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");

	prdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");

	protection_active_bit_read_a: assert property (psel && penable && !pwrite && pready // see RL2
		&& hit(paddr, `PCP_IDX_PROTECTION_ACTIVE_BIT) |-> prdata[31:1] == 31'h0000_0000)
		else $error("protect read upper bits set");

	// guarded writes land while unlocked
	mult_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_MULT) // see RL3
		&& !s_reg.protection_active_bit |=> s_reg.vco_multiplier == $past(pwdata[5:0]))
		else $error("multiplier write lost");

	reference_divider_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_REFERENCE_DIVIDER) // see RL3
		&& !s_reg.protection_active_bit |=> s_reg.reference_divider == $past(pwdata[3:0]))
		else $error("reference divider write lost");

	post_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_PLLCFG) // see RL3
		&& !s_reg.protection_active_bit |=> s_reg.output_post_divider == $past(pwdata[4:0]))
		else $error("post divider write lost");

	trim_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_TRIML) // see RL3
		&& !s_reg.protection_active_bit |=> s_reg.trim_low == $past(pwdata[7:0]))
		else $error("trim write lost");

	osc_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_OSC) // see RL3
		&& !s_reg.protection_active_bit |=> s_reg.osc_enable_bit == $past(pwdata[7]))
		else $error("oscillator enable write lost");

	trim_cfg_a: assert property (clk_cfg.rc_trim == {s_reg.trim_high, s_reg.trim_low}) // see RL1
		else $error("trim setting not presented");

	// clock choice
	bus_div_a: assert property (clk_cfg.bus_div == 2'h2) // see RL9
		else $error("bus divider not two");

	sys_pll_a: assert property (clk_cfg.sys_from_pll == s_reg.pll_source_select) // see RL9
		else $error("pll source not presented");

	sys_osc_a: assert property (clk_cfg.sys_from_osc |-> !clk_cfg.sys_from_pll) // see RL11
		else $error("two system clock sources");

	stop_force_a: assert property (full_stop |=> s_reg.pll_source_select) // see RL12
		else $error("full stop did not force pll select");

	// lock change flag
	mask_write_a: assert property (data_wr && hit(paddr, `PCP_IDX_MASK) // see RL13
		|=> s_reg.lock_change_irq_enable == $past(pwdata[0]))
		else $error("irq enable write lost");

	flag_clear_a: assert property (data_wr && hit(paddr, `PCP_IDX_STATUS) && pwdata[0] // see RL13
		&& s_reg.lock_sync == s_reg.lock_prev |=> !s_reg.lock_change_flag)
		else $error("lock flag not cleared");

	irq_low_a: assert property (!(s_reg.lock_change_flag && s_reg.lock_change_irq_enable) // see RL13
		|-> !irq) else $error("interrupt without cause");

	unlock_c: cover property (protection_active_bit_wr && pwdata[7:0] == `PCP_UNLOCK_KEY);
	osc_sys_c: cover property (clk_cfg.sys_from_osc);
	guard_c: cover property (s_reg.protection_active_bit && psel && penable && pwrite
		&& pready && hit(paddr, `PCP_IDX_MULT));
	irq_c: cover property (!irq ##1 irq);
	unlocked_c: cover property (s_reg.lock_prev && !s_reg.lock_sync);

endmodule

// ==== pcp_regs.svh ====
/*
 * register indices, field positions, reset values and keys of the clock configuration block.
 * assumes byte address = index * 4 on a 32-bit apb bus.
 */
`ifndef PCP_REGS_SVH
`define PCP_REGS_SVH

`define PCP_ADDR_W 12
`define PCP_IDX_MULT 10'h2E4
`define PCP_IDX_REFERENCE_DIVIDER 10'h2E5
`define PCP_IDX_STATUS 10'h2E7
`define PCP_IDX_MASK 10'h2E8
`define PCP_IDX_CLKSEL 10'h2E9
`define PCP_IDX_PLLCFG 10'h2EA
`define PCP_IDX_TRIMH 10'h2F8
`define PCP_IDX_TRIML 10'h2F9
`define PCP_IDX_OSC 10'h2FA
`define PCP_IDX_PROTECTION_ACTIVE_BIT 10'h2FB
`define PCP_IDX_OSC2 10'h2FF

`define PCP_UNLOCK_KEY 8'h26
`define PCP_BIT_PLL_SEL 7
`define PCP_BIT_OSC_EN 7
`define PCP_BIT_LOCK_FLAG 0
`define PCP_BIT_LOCK_STAT 3
`define PCP_BIT_PROTECTION_ACTIVE_BIT 0

`define PCP_RST_MULT 6'h00
`define PCP_RST_REFERENCE_DIVIDER 4'h0
`define PCP_RST_POST 5'h03
`define PCP_RST_TRIM 8'h00
`define PCP_RST_OSC2 2'h0
`define PCP_UNLOCKED_DIV 6'h04
`define PCP_BUS_DIV 2'h2

`endif

// ==== pcp_pkg.sv ====
/*
 * types of the clock configuration block: state record and clock setting record.
 * assumes pcp_regs.svh is compiled alongside.
 */
package pcp_pkg;

	typedef struct packed {
		logic ref_from_osc;
		logic [4:0] ref_div;
		logic [7:0] vco_mult;
		logic [5:0] pll_div;
		logic sys_from_pll;
		logic sys_from_osc;
		logic [1:0] bus_div;
		logic [15:0] rc_trim;
		logic [1:0] osc_mode;
	} pcp_clk_cfg_type;

	typedef struct packed {
		logic protection_active_bit;
		logic [5:0] vco_multiplier;
		logic [3:0] reference_divider;
		logic [4:0] output_post_divider;
		logic pll_source_select;
		logic osc_enable_bit;
		logic [7:0] trim_high;
		logic [7:0] trim_low;
		logic [1:0] osc_mode;
		logic lock_meta;
		logic lock_sync;
		logic lock_prev;
		logic lock_change_flag;
		logic lock_change_irq_enable;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		pcp_clk_cfg_type cfg;
	} pcp_state_type;

endpackage

// ==== pll_clock_config_protect_tb.sv ====
/*
 * self-checking testbench of the clock configuration block, driven over apb.
 * assumes pcp_regs.svh, pcp_pkg and pcp_clock_ctrl are compiled before it.
 */
`timescale 1ns/100ps
`include "pcp_regs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("Error at %0t: got %h expected %h", $time, a, e); end end

module pll_clock_config_protect_tb
	import pcp_pkg::*;
;
	logic core_clk, rstn, clk_en, psel, penable, pwrite, pll_lock_in, osc_qualified, full_stop;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic pready, pslverr, irq, err;
	pcp_clk_cfg_type clk_cfg;
	int errors, comparisons;

	pcp_clock_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pll_lock_in(pll_lock_in),
		.osc_qualified(osc_qualified), .full_stop(full_stop), .irq(irq), .clk_cfg(clk_cfg));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task results;
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one apb transfer; read data and error taken at the falling edge that sees pready
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		`CHK(pready, 1'b1)
		rdata = prdata;
		err = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task settle;
		repeat (5) @(posedge core_clk);
	endtask

	initial
	begin
		#(50 * 5000);
		errors++;
		results;
	end

	initial
	begin
		{rstn, psel, penable, pwrite, pll_lock_in, osc_qualified, full_stop} = '0;
		clk_en = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		settle;
		`CHK(clk_cfg.vco_mult, 8'h02)
		`CHK(clk_cfg.pll_div, 6'h04)
		`CHK(clk_cfg.ref_from_osc, 1'b0)
		xfer(1'b0, `PCP_IDX_PROTECTION_ACTIVE_BIT, 32'h0000_0000);
		`CHK(rdata, 32'h0000_0000)
		xfer(1'b1, `PCP_IDX_MULT, 32'h0000_003F);
		xfer(1'b1, `PCP_IDX_REFERENCE_DIVIDER, 32'h0000_000F);
		xfer(1'b1, `PCP_IDX_PLLCFG, 32'h0000_001F);
		settle;
		`CHK(clk_cfg.vco_mult, 8'h80)
		`CHK(clk_cfg.ref_div, 5'h01)
		`CHK(clk_cfg.pll_div, 6'h04)
		xfer(1'b1, `PCP_IDX_OSC, 32'h0000_0080);
		settle;
		`CHK(clk_cfg.ref_from_osc, 1'b1)
		`CHK(clk_cfg.ref_div, 5'h10)
		pll_lock_in <= 1'b1;
		settle;
		`CHK(clk_cfg.pll_div, 6'h20)
		`CHK(irq, 1'b0)
		xfer(1'b0, `PCP_IDX_STATUS, 32'h0000_0000);
		`CHK(rdata, 32'h0000_0009)
		xfer(1'b1, `PCP_IDX_MASK, 32'h0000_0001);
		settle;
		`CHK(irq, 1'b1)
		xfer(1'b1, `PCP_IDX_STATUS, 32'h0000_0000);
		settle;
		`CHK(irq, 1'b1)
		xfer(1'b1, `PCP_IDX_STATUS, 32'h0000_0001);
		settle;
		`CHK(irq, 1'b0)
		pll_lock_in <= 1'b0;
		settle;
		`CHK(irq, 1'b1)
		`CHK(clk_cfg.pll_div, 6'h04)
		xfer(1'b1, `PCP_IDX_STATUS, 32'h0000_0001);
		xfer(1'b1, `PCP_IDX_PROTECTION_ACTIVE_BIT, 32'h0000_0025);
		xfer(1'b0, `PCP_IDX_PROTECTION_ACTIVE_BIT, 32'h0000_0000);
		`CHK(rdata, 32'h0000_0001)
		xfer(1'b1, `PCP_IDX_MULT, 32'h0000_0000);
		xfer(1'b1, `PCP_IDX_TRIML, 32'h0000_00A5);
		settle;
		`CHK(clk_cfg.vco_mult, 8'h80)
		`CHK(clk_cfg.rc_trim, 16'h0000)
		xfer(1'b1, `PCP_IDX_PROTECTION_ACTIVE_BIT, 32'h0000_0026);
		xfer(1'b0, `PCP_IDX_PROTECTION_ACTIVE_BIT, 32'h0000_0000);
		`CHK(rdata, 32'h0000_0000)
		xfer(1'b1, `PCP_IDX_MULT, 32'h0000_0000);
		settle;
		`CHK(clk_cfg.vco_mult, 8'h02)
		xfer(1'b1, `PCP_IDX_CLKSEL, 32'h0000_0000);
		settle;
		`CHK(clk_cfg.sys_from_pll, 1'b1)
		osc_qualified <= 1'b1;
		xfer(1'b1, `PCP_IDX_CLKSEL, 32'h0000_0000);
		settle;
		`CHK(clk_cfg.sys_from_pll, 1'b0)
		`CHK(clk_cfg.sys_from_osc, 1'b1)
		`CHK(clk_cfg.bus_div, 2'h2)
		full_stop <= 1'b1;
		settle;
		`CHK(clk_cfg.sys_from_pll, 1'b1)
		full_stop <= 1'b0;
		xfer(1'b0, 10'h000, 32'h0000_0000);
		`CHK(err, 1'b1)
		`CHK(rdata, 32'h0000_0000)
		results;
	end
endmodule
